// File: src/sfc5_pkg.sv
// Constants and types shared by the serial frame CRC-5 checker.
package sfc5_pkg;

  localparam int unsigned FRAME_BITS = 32;
  localparam int unsigned CRC_BITS   = 5;
  localparam int unsigned LOOP_BITS  = 6;

  // Loop seed 010001 and the polynomial x^5 + x^2 + 1 as 100101.
  localparam logic [5:0] LOOP_SEED = 6'h11;
  localparam logic [5:0] LOOP_POLY = 6'h25;

  // Command frame field positions.
  localparam int unsigned CMD_NODE_MSB = 31;
  localparam int unsigned CMD_NODE_LSB = 30;
  localparam int unsigned CMD_BODY_MSB = 26;

  // Response frame field positions.
  localparam int unsigned RSP_VALID_BIT = 29;
  localparam int unsigned RSP_FAULT_BIT = 28;
  localparam int unsigned RSP_COUNT_MSB = 23;
  localparam int unsigned RSP_COUNT_LSB = 20;
  localparam int unsigned RSP_DATA_MSB  = 19;
  localparam int unsigned RSP_DATA_LSB  = 5;

  localparam logic [5:0]  LAST_SHIFT   = 6'h1F;
  localparam logic [31:0] RESP_RESET   = 32'h0000_0000;
  localparam logic [3:0]  COUNT_RESET  = 4'h0;

  typedef enum logic [2:0] {
    SFC5_IDLE  = 3'b000,
    SFC5_CHECK = 3'b001,
    SFC5_JUDGE = 3'b010,
    SFC5_BUILD = 3'b011,
    SFC5_SEND  = 3'b100
  } sfc5_state_t;

endpackage : sfc5_pkg

// File: src/sfc5_link.sv
// Link-clock side of the serial port: bit shifting in and out of a 32-bit frame.
`timescale 1ns/1ns
`default_nettype none
module sfc5_link (
  // Link clock and reset
  input  wire logic        spi_sclk,
  input  wire logic        rst_n,
  // Serial pins
  input  wire logic        spi_cs_n,
  input  wire logic        spi_mosi,
  output logic             spi_miso,
  // Frame exchange with the core domain
  input  wire logic [31:0] resp_word,
  output logic [31:0]      frame_word,
  output logic             frame_tgl
);

  typedef struct packed {
    logic [4:0]  cnt;
    logic [30:0] sh_in;
    logic [30:0] sh_out;
    logic        miso;
    logic [31:0] frame;
    logic        tgl;
  } sfc5_link_st_t;

  sfc5_link_st_t q;
  sfc5_link_st_t d;

  always_comb
  begin
    d = q;
    if (!spi_cs_n)
    begin
      // The response word is static between frames, so it is loaded at the first edge.
      if (q.cnt == 5'h00)
      begin
        d.miso   = resp_word[31];
        d.sh_out = resp_word[30:0];
      end
      else
      begin
        d.miso   = q.sh_out[30];
        d.sh_out = {q.sh_out[29:0], 1'b0};
      end
      d.sh_in = {q.sh_in[29:0], spi_mosi};
      if (q.cnt == 5'h1F)
      begin
        d.frame = {q.sh_in, spi_mosi};
        d.tgl   = ~q.tgl;
      end
      d.cnt = q.cnt + 5'h01;
    end
  end

  always_ff @(posedge spi_sclk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end

  assign spi_miso   = q.miso;
  assign frame_word = q.frame;
  assign frame_tgl  = q.tgl;

  AST_LINK_TOGGLE: assert property (@(posedge spi_sclk) disable iff (!rst_n)
    (!spi_cs_n && q.cnt == 5'h1F) |=> (q.tgl != $past(q.tgl)))
    else $error("Frame toggle did not flip after the 32nd bit.");

endmodule : sfc5_link
`default_nettype wire

// File: src/sfc5_checker.sv
// Serial frame CRC-5 checker and response CRC generator, core clock side.
`timescale 1ns/1ns
`default_nettype none
module sfc5_checker (
  // Core clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Link clock and serial pins
  input  wire logic        spi_sclk,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_mosi,
  output logic             spi_miso,
  output logic             spi_miso_oe,
  // Device side
  input  wire logic [14:0] status_data,
  input  wire logic        fault_clr,
  output logic [26:0]      cmd_body,
  output logic             cmd_valid,
  output logic             serial_error_flag,
  output logic             global_fault_flag
);

  typedef struct packed {
    sfc5_pkg::sfc5_state_t state;
    logic [5:0]            loop;
    logic [31:0]           buffer;
    logic [5:0]            cnt;
    logic [31:0]           rx;
    logic                  ok;
    logic                  serr;
    logic                  gflt;
    logic [31:0]           resp;
    logic [3:0]            frames;
    logic [26:0]           cmd;
    logic                  cmd_valid;
    logic [2:0]            tsync;
    logic [1:0]            cs_sync;
    logic                  oe;
  } sfc5_core_st_t;

  sfc5_core_st_t q;
  sfc5_core_st_t d;

  logic [31:0] frame_word;
  logic        frame_tgl;
  logic        frame_edge;
  logic        link_miso;

  // One step of the division loop.
  function automatic logic [5:0] sfc5_step(input logic [5:0] loop_in, input logic bit_in);
    logic [5:0] t;
    t = {loop_in[4:0], bit_in};
    if (t[5])
      t = t ^ sfc5_pkg::LOOP_POLY;
    return t;
  endfunction : sfc5_step

  // Whole-buffer division from the seed.
  function automatic logic [5:0] sfc5_divide(input logic [31:0] word);
    logic [5:0] l;
    l = sfc5_pkg::LOOP_SEED;
    for (int i = 31; i >= 0; i--)
      l = sfc5_step(l, word[i]);
    return l;
  endfunction : sfc5_divide

  sfc5_link u_link (
    .spi_sclk   (spi_sclk),
    .rst_n      (rst_n),
    .spi_cs_n   (spi_cs_n),
    .spi_mosi   (spi_mosi),
    .spi_miso   (link_miso),
    .resp_word  (q.resp),
    .frame_word (frame_word),
    .frame_tgl  (frame_tgl)
  );

  // The first synchroniser stage feeds only the second; the edge uses stages two and three.
  assign frame_edge = q.tsync[1] ^ q.tsync[2];

  always_comb
  begin
    d           = q;
    d.cmd_valid = 1'b0;
    d.tsync     = {q.tsync[1:0], frame_tgl};
    d.cs_sync   = {q.cs_sync[0], spi_cs_n};
    d.oe        = ~q.cs_sync[1];
    if (fault_clr)
    begin
      d.serr = 1'b0;
      d.gflt = 1'b0;
    end
    case (q.state)
      sfc5_pkg::SFC5_IDLE:
      begin
        if (frame_edge)
        begin
          d.rx     = frame_word;
          d.buffer = frame_word;
          d.loop   = sfc5_pkg::LOOP_SEED;
          d.cnt    = 6'h00;
          d.state  = sfc5_pkg::SFC5_CHECK;
        end
      end
      sfc5_pkg::SFC5_CHECK:
      begin
        d.loop   = sfc5_step(q.loop, q.buffer[31]);
        d.buffer = {q.buffer[30:0], 1'b0};
        d.cnt    = q.cnt + 6'h01;
        if (q.cnt == sfc5_pkg::LAST_SHIFT)
          d.state = sfc5_pkg::SFC5_JUDGE;
      end
      sfc5_pkg::SFC5_JUDGE:
      begin
        d.ok     = (q.loop[4:0] == 5'h00);
        d.frames = q.frames + 4'h1;
        if (q.loop[4:0] != 5'h00)
        begin
          d.serr = 1'b1;
          d.gflt = 1'b1;
        end
        else
        begin
          d.cmd       = q.rx[sfc5_pkg::CMD_BODY_MSB:0];
          d.cmd_valid = 1'b1;
        end
        // Response body with five zero bits for the remainder.
        d.buffer = {q.rx[sfc5_pkg::CMD_NODE_MSB:sfc5_pkg::CMD_NODE_LSB],
                    (q.loop[4:0] == 5'h00),
                    (q.loop[4:0] != 5'h00) | d.gflt,
                    4'h0, d.frames, status_data, 5'h00};
        d.loop   = sfc5_pkg::LOOP_SEED;
        d.cnt    = 6'h00;
        d.state  = sfc5_pkg::SFC5_BUILD;
      end
      sfc5_pkg::SFC5_BUILD:
      begin
        d.loop   = sfc5_step(q.loop, q.buffer[31]);
        d.buffer = {q.buffer[30:0], 1'b0};
        d.cnt    = q.cnt + 6'h01;
        if (q.cnt == 6'h00)
          d.resp = q.buffer;
        if (q.cnt == sfc5_pkg::LAST_SHIFT)
          d.state = sfc5_pkg::SFC5_SEND;
      end
      sfc5_pkg::SFC5_SEND:
      begin
        d.resp[4:0] = q.loop[4:0];
        d.state     = sfc5_pkg::SFC5_IDLE;
      end
      default:
      begin
        d.state = sfc5_pkg::SFC5_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q        <= '0;
      q.state  <= sfc5_pkg::SFC5_IDLE;
      q.loop   <= sfc5_pkg::LOOP_SEED;
      q.resp   <= sfc5_pkg::RESP_RESET;
      q.frames <= sfc5_pkg::COUNT_RESET;
      q.tsync  <= 3'h0;
      q.cs_sync <= 2'h3;
    end
    else
    begin
      q <= d;
    end
  end

  assign spi_miso          = link_miso;
  assign spi_miso_oe       = q.oe;
  assign cmd_body          = q.cmd;
  assign cmd_valid         = q.cmd_valid;
  assign serial_error_flag = q.serr;
  assign global_fault_flag = q.gflt;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  AST_SEED_LOAD: assert property ((q.state == sfc5_pkg::SFC5_IDLE && frame_edge)
    |=> (q.loop == sfc5_pkg::LOOP_SEED && q.buffer == q.rx))
    else $error("Loop not seeded or buffer not loaded at frame start.");

  AST_CHECK_LENGTH: assert property ((q.state == sfc5_pkg::SFC5_IDLE && frame_edge)
    |=> (q.state == sfc5_pkg::SFC5_CHECK) [*8] ##25 (q.state == sfc5_pkg::SFC5_JUDGE))
    else $error("Check did not take exactly 32 shifts.");

  AST_REMAINDER: assert property ((q.state == sfc5_pkg::SFC5_JUDGE)
    |-> (q.loop == sfc5_divide(q.rx)))
    else $error("Loop content differs from the division of the frame.");

  AST_ERROR_FLAGS: assert property ((q.state == sfc5_pkg::SFC5_JUDGE && q.loop[4:0] != 5'h00)
    |=> (serial_error_flag && global_fault_flag && !cmd_valid))
    else $error("Bad remainder did not raise both fault flags.");

  AST_GOOD_FRAME: assert property ((q.state == sfc5_pkg::SFC5_JUDGE && q.loop[4:0] == 5'h00)
    |=> (cmd_valid && cmd_body == q.rx[26:0]))
    else $error("Good frame was not delivered.");

  AST_SET_WINS: assert property ((fault_clr && q.state == sfc5_pkg::SFC5_JUDGE && q.loop[4:0] != 5'h00)
    |=> serial_error_flag)
    else $error("Clear overrode a simultaneous error.");

  AST_RESP_VALID: assert property ((q.state == sfc5_pkg::SFC5_JUDGE)
    |-> ##34 (q.resp[sfc5_pkg::RSP_VALID_BIT] == $past(q.ok, 33)))
    else $error("Response valid bit does not match the check result.");

  AST_RESP_CRC: assert property ((q.state == sfc5_pkg::SFC5_SEND)
    |=> (sfc5_divide({q.resp[31:5], 5'h00}) == {1'b0, q.resp[4:0]} ||
         sfc5_divide({q.resp[31:5], 5'h00}) == ({1'b1, q.resp[4:0]})))
    else $error("Response CRC does not match its fields.");

  AST_CMD_PULSE: assert property (cmd_valid |=> !cmd_valid)
    else $error("Command valid stood for more than one cycle.");

  AST_CMD_ONLY_GOOD: assert property (cmd_valid |-> q.ok)
    else $error("Command delivered from a frame that failed the check.");

  AST_RX_HOLD: assert property ((q.state != sfc5_pkg::SFC5_IDLE) |=> $stable(q.rx))
    else $error("Received frame changed while it was being handled.");

  AST_IDLE_WAIT: assert property ((q.state == sfc5_pkg::SFC5_IDLE && !frame_edge)
    |=> (q.state == sfc5_pkg::SFC5_IDLE))
    else $error("Check started without a completed frame.");

  AST_CHECK_SHIFT: assert property ((q.state == sfc5_pkg::SFC5_CHECK)
    |=> (q.buffer == ($past(q.buffer) << 1)))
    else $error("Buffer did not shift its top bit into the loop.");

  AST_LOOP_TOP_CLEAR: assert property ((q.state == sfc5_pkg::SFC5_CHECK || q.state == sfc5_pkg::SFC5_BUILD)
    |=> !q.loop[5])
    else $error("Stage five still held a one after the polynomial step.");

  AST_BUILD_SEED: assert property ((q.state == sfc5_pkg::SFC5_JUDGE)
    |=> (q.loop == sfc5_pkg::LOOP_SEED))
    else $error("Loop not seeded before the response division.");

  AST_BUILD_SHIFT: assert property ((q.state == sfc5_pkg::SFC5_BUILD)
    |=> (q.buffer == ($past(q.buffer) << 1)))
    else $error("Response buffer did not shift into the loop.");

  AST_BUILD_LENGTH: assert property ((q.state == sfc5_pkg::SFC5_JUDGE)
    |=> (q.state == sfc5_pkg::SFC5_BUILD) [*8] ##25 (q.state == sfc5_pkg::SFC5_SEND))
    else $error("Response division did not take exactly 32 shifts.");

  AST_SEND_RETURN: assert property ((q.state == sfc5_pkg::SFC5_SEND)
    |=> (q.state == sfc5_pkg::SFC5_IDLE))
    else $error("Send step did not return to idle.");

  AST_COUNT_STEP: assert property ((q.state == sfc5_pkg::SFC5_JUDGE)
    |=> (q.frames == $past(q.frames) + 4'h1))
    else $error("Frame count did not advance by one per checked frame.");

  AST_RESP_COUNT: assert property ((q.state == sfc5_pkg::SFC5_SEND)
    |=> (q.resp[sfc5_pkg::RSP_COUNT_MSB:sfc5_pkg::RSP_COUNT_LSB] == q.frames))
    else $error("Response frame count differs from the checked frame count.");

  AST_RESP_STATUS: assert property ((q.state == sfc5_pkg::SFC5_JUDGE)
    |=> ##1 (q.resp[sfc5_pkg::RSP_DATA_MSB:sfc5_pkg::RSP_DATA_LSB] == $past(status_data, 2)))
    else $error("Response status field differs from the sampled status.");

  AST_RESP_FAULT: assert property ((q.state == sfc5_pkg::SFC5_JUDGE)
    |=> ##1 (q.resp[sfc5_pkg::RSP_FAULT_BIT] == $past(global_fault_flag)))
    else $error("Response fault bit differs from the fault flag.");

  AST_FLAG_CAUSE: assert property ($rose(serial_error_flag)
    |-> ($past(q.state) == sfc5_pkg::SFC5_JUDGE))
    else $error("Serial error flag rose outside the check verdict.");

  AST_SERR_STICKY: assert property ((serial_error_flag && !fault_clr) |=> serial_error_flag)
    else $error("Serial error flag fell without a clear.");

  AST_GFLT_STICKY: assert property ((global_fault_flag && !fault_clr) |=> global_fault_flag)
    else $error("Global fault flag fell without a clear.");

  AST_FLAGS_CLEAR: assert property ((fault_clr && q.state != sfc5_pkg::SFC5_JUDGE)
    |=> (!serial_error_flag && !global_fault_flag))
    else $error("Clear did not drop both fault flags.");

  AST_OE_FOLLOWS: assert property ($rose(spi_miso_oe) |-> !$past(spi_cs_n, 3))
    else $error("Output enable rose without a selected frame.");

  CVR_GOOD: cover property ((q.state == sfc5_pkg::SFC5_JUDGE && q.loop[4:0] == 5'h00));
  CVR_BAD: cover property ((q.state == sfc5_pkg::SFC5_JUDGE && q.loop[4:0] != 5'h00));
  CVR_SENT: cover property ((q.state == sfc5_pkg::SFC5_SEND) ##1 frame_edge);
  CVR_SET_WINS: cover property ((fault_clr && q.state == sfc5_pkg::SFC5_JUDGE && q.loop[4:0] != 5'h00));
  CVR_CLEAR: cover property ((fault_clr && serial_error_flag));

endmodule : sfc5_checker
`default_nettype wire

// File: test/sfc5_host.sv
// Host model that sends 32-bit command frames and captures the response.
`timescale 1ns/1ns
`default_nettype none
module sfc5_host (
  // Serial pins
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_mosi,
  input  wire logic spi_miso
);
  logic [31:0] rx_word;
  initial
  begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // The clock stands still between frames, and the line flips once the frame is over.
  task automatic xfer(input logic [31:0] tx, input int d);
    #(d) spi_cs_n = 1'b0;
    for (int i = 31; i >= 0; i--)
    begin
      spi_mosi = tx[i];
      #40 spi_sclk = 1'b1;
      #40 rx_word[i] = spi_miso;
      spi_sclk = 1'b0;
    end
    #40 spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
  endtask : xfer
endmodule : sfc5_host
`default_nettype wire

// File: test/serial_frame_crc5_checker_tb.sv
// Self-checking testbench for the serial frame CRC-5 checker.
`timescale 1ns/1ns
`default_nettype none
module serial_frame_crc5_checker_tb;
  logic        ref_clk;
  logic        rst_n;
  logic [14:0] status_data;
  logic        fault_clr;
  wire logic   spi_sclk;
  wire logic   spi_cs_n;
  wire logic   spi_mosi;
  wire logic   spi_miso;
  wire logic   spi_miso_oe;
  logic [26:0] cmd_body;
  logic        cmd_valid;
  logic        serial_error_flag;
  logic        global_fault_flag;
  int          seed;
  int          n_fail;
  int          total_checks;
  logic        fault;
  logic [3:0]  cnt;
  logic [26:0] body_exp;
  logic [31:0] resp_exp;
  logic [26:0] body;
  logic [31:0] mask;

  sfc5_checker dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .status_data(status_data), .fault_clr(fault_clr), .cmd_body(cmd_body),
    .cmd_valid(cmd_valid), .serial_error_flag(serial_error_flag),
    .global_fault_flag(global_fault_flag)
  );
  sfc5_host u_host (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso));

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  function automatic logic [4:0] crc5(input logic [26:0] f);
    logic [31:0] d;
    logic [5:0]  r;
    d = {f, 5'h00};
    r = sfc5_pkg::LOOP_SEED;
    for (int i = 31; i >= 0; i--)
    begin
      r = {r[4:0], d[i]};
      if (r[5]) r = r ^ sfc5_pkg::LOOP_POLY;
    end
    return r[4:0];
  endfunction : crc5

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic results;
    if (n_fail == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results

  // One frame out, the response to the previous frame checked, then the verdict of the core observed.
  task automatic frame(input logic [26:0] f, input logic [31:0] m, input logic hold_clr);
    logic [31:0] tx;
    logic [26:0] rf;
    logic        bad;
    logic        seen;
    bad = |m;
    tx = {f, crc5(f)} ^ m;
    u_host.xfer(tx, 1 + ($unsigned($random(seed)) % 37));
    chk(u_host.rx_word, resp_exp);
    chk(spi_miso_oe, 1'b1);
    seen = 1'b0;
    @(posedge ref_clk);
    fault_clr <= hold_clr;
    // A clear held across the verdict must lose to the error; it is dropped once the flag shows.
    for (int i = 0; i < 80; i++)
    begin
      @(posedge ref_clk) #1;
      if (cmd_valid === 1'b1) seen = 1'b1;
      if (serial_error_flag === 1'b1 || i == 79) fault_clr <= 1'b0;
    end
    chk(spi_miso_oe, 1'b0);
    chk(seen, !bad);
    if (!bad) body_exp = tx[26:0];
    fault = fault | bad;
    cnt = cnt + 4'h1;
    chk(cmd_body, body_exp);
    chk(serial_error_flag, fault);
    chk(global_fault_flag, fault);
    rf = {tx[31:30], ~bad, fault, 4'h0, cnt, status_data};
    resp_exp = {rf, crc5(rf)};
  endtask : frame

  initial
  begin
    seed = 40145;
    n_fail = 0;
    total_checks = 0;
    rst_n = 1'b0;
    fault_clr = 1'b0;
    status_data = 15'h0000;
    fault = 1'b0;
    cnt = sfc5_pkg::COUNT_RESET;
    body_exp = 27'h0000000;
    resp_exp = sfc5_pkg::RESP_RESET;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 chk({serial_error_flag, global_fault_flag, cmd_valid, spi_miso_oe}, 32'h0);
    for (int i = 0; i < 20; i++)
    begin
      @(posedge ref_clk);
      status_data <= 15'($random(seed));
      body = (i == 0) ? 27'h0000000 : (i == 1) ? 27'h7FFFFFF : 27'($random(seed));
      mask = (i == 4) ? 32'h8000_0000 : (i == 5) ? 32'h0000_0001 : (i == 11) ? 32'h0001_0000 :
             (i == 15) ? 32'h0000_0400 : 32'h0;
      frame(body, mask, i == 15);
      if (i == 6 || i == 12)
      begin
        @(posedge ref_clk);
        fault_clr <= 1'b1;
        @(posedge ref_clk);
        fault_clr <= 1'b0;
        @(posedge ref_clk) #1;
        fault = 1'b0;
        chk({serial_error_flag, global_fault_flag}, 32'h0);
      end
    end
    results();
  end
endmodule : serial_frame_crc5_checker_tb
`default_nettype wire
